// ===== shared/mcf_pkg.sv
package mcf_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	// One processor cycle at the top 1 MHz rate.
	localparam int unsigned PROC_CYCLE_NS = 1000;
	localparam int unsigned CLKS_PER_CYC  = (PROC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_OPCODE  = 8'h00;
	localparam logic [7:0] ADDR_OPERAND = 8'h04;
	localparam logic [7:0] ADDR_ACC     = 8'h08;
	localparam logic [7:0] ADDR_CCR     = 8'h0C;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_RESULT  = 8'h14;
	localparam logic [7:0] ADDR_INTREQ  = 8'h18;
	localparam logic [7:0] ADDR_INDEX   = 8'h1C;
	localparam logic [7:0] ADDR_PC      = 8'h20;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_BRANCH_SUB   = 8'h8D;
	localparam logic [7:0] OP_JUMP_SUB_EXT = 8'hBD;
	localparam logic [7:0] OP_JUMP_SUB_IDX = 8'hAD;
	localparam logic [7:0] OP_JUMP_EXT     = 8'h7E;
	localparam logic [7:0] OP_JUMP_IDX     = 8'h6E;
	localparam logic [7:0] OP_SUB_RETURN   = 8'h39;
	localparam logic [7:0] OP_INT_RETURN   = 8'h3B;
	localparam logic [7:0] OP_SOFT_TRAP    = 8'h3F;
	localparam logic [7:0] OP_IDLE_WAIT    = 8'h3E;
	localparam logic [7:0] OP_NO_OPERATION = 8'h02;
	localparam logic [7:0] OP_CLEAR_ACC_A  = 8'h4F;
	localparam logic [7:0] OP_CLEAR_ACC_B  = 8'h5F;
	localparam logic [7:0] OP_CLEAR_EXT    = 8'h7F;
	localparam logic [7:0] OP_CLEAR_IDX    = 8'h6F;
	localparam logic [7:0] OP_CLEAR_CARRY  = 8'h0C;
	localparam logic [7:0] OP_CLEAR_MASK   = 8'h0E;
	localparam logic [7:0] OP_CLEAR_OVF    = 8'h0A;
	localparam logic [7:0] OP_SET_CARRY    = 8'h0D;
	localparam logic [7:0] OP_SET_MASK     = 8'h0F;
	localparam logic [7:0] OP_SET_OVF      = 8'h0B;
	localparam logic [7:0] OP_NEGATE_A     = 8'h40;
	localparam logic [7:0] OP_DEC_ADJUST   = 8'h19;
	localparam logic [7:0] OP_DEC_A        = 8'h4A;
	localparam logic [7:0] OP_INC_A        = 8'h4C;
	localparam logic [7:0] OP_COMPARE_IDX  = 8'h8C;
	localparam logic [7:0] OP_LOAD_IDX     = 8'hCE;
	localparam logic [7:0] OP_ACC_TO_CCR   = 8'h06;

	// ----------------------------------------------------------------
	// Flag positions, reset values and arithmetic constants
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_V = 1;
	localparam int unsigned FLAG_Z = 2;
	localparam int unsigned FLAG_N = 3;
	localparam int unsigned FLAG_I = 4;
	localparam int unsigned FLAG_H = 5;
	localparam logic [5:0]  CCR_RESET     = 6'h10;
	localparam logic [7:0]  BYTE_MIN_NEG  = 8'h80;
	localparam logic [7:0]  BYTE_MAX_POS  = 8'h7F;
	localparam logic [7:0]  BYTE_ONE      = 8'h01;
	localparam logic [3:0]  BCD_MAX_DIGIT = 4'h9;
	localparam logic [3:0]  BCD_HI_LIMIT  = 4'h8;
	localparam logic [3:0]  BCD_CORR      = 4'h6;
	localparam logic [15:0] PC_REL_BASE   = 16'h0002;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MCF_IDLE = 2'b00,
		MCF_EXEC = 2'b01,
		MCF_WAIT = 2'b10
	} mcf_state_type;

	typedef struct packed {
		logic       known;
		logic [3:0] cycles;
		logic [1:0] bytes;
	} mcf_decode_type;

	typedef struct packed {
		logic [5:0]  ccr;
		logic [7:0]  accA;
		logic [7:0]  accB;
		logic [15:0] index;
		logic [15:0] pc;
		logic [15:0] result;
	} mcf_arch_type;

	typedef struct packed {
		logic [13:0] zero;
		logic [1:0]  state;
		logic        maskAtWait;
		logic        nmiPending;
		logic        irqPending;
		logic        illegal;
		logic [3:0]  rsvd;
		logic [1:0]  bytes;
		logic [3:0]  cycles;
		logic [1:0]  rsvdLow;
	} mcf_status_type;

endpackage

// ===== hw/mcf_control_flow.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module mcf_control_flow #(
	parameter int unsigned CLKS_PER_CYC = mcf_pkg::CLKS_PER_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             cpuWaiting
);

	// ----------------------------------------------------------------
	// Opcode decode
	// ----------------------------------------------------------------
	// Cycle counts and lengths live in one table so sequencer and status agree.
	function automatic mcf_pkg::mcf_decode_type decodeOp(input logic [7:0] op);
		mcf_pkg::mcf_decode_type d;
		d = '{known: 1'b1, cycles: 4'h2, bytes: 2'h1};
		case (op)
			mcf_pkg::OP_BRANCH_SUB:   d = '{1'b1, 4'h8, 2'h2};
			mcf_pkg::OP_JUMP_SUB_EXT: d = '{1'b1, 4'h9, 2'h3};
			mcf_pkg::OP_JUMP_SUB_IDX: d = '{1'b1, 4'h8, 2'h2};
			mcf_pkg::OP_JUMP_EXT:     d = '{1'b1, 4'h3, 2'h3};
			mcf_pkg::OP_JUMP_IDX:     d = '{1'b1, 4'h4, 2'h2};
			mcf_pkg::OP_SUB_RETURN:   d = '{1'b1, 4'h5, 2'h1};
			mcf_pkg::OP_INT_RETURN:   d = '{1'b1, 4'hA, 2'h1};
			mcf_pkg::OP_SOFT_TRAP:    d = '{1'b1, 4'hC, 2'h1};
			mcf_pkg::OP_IDLE_WAIT:    d = '{1'b1, 4'h9, 2'h1};
			mcf_pkg::OP_CLEAR_EXT:    d = '{1'b1, 4'h6, 2'h3};
			mcf_pkg::OP_CLEAR_IDX:    d = '{1'b1, 4'h7, 2'h2};
			mcf_pkg::OP_COMPARE_IDX:  d = '{1'b1, 4'h3, 2'h3};
			mcf_pkg::OP_LOAD_IDX:     d = '{1'b1, 4'h3, 2'h3};
			mcf_pkg::OP_NO_OPERATION, mcf_pkg::OP_CLEAR_ACC_A, mcf_pkg::OP_CLEAR_ACC_B,
			mcf_pkg::OP_CLEAR_CARRY, mcf_pkg::OP_CLEAR_MASK, mcf_pkg::OP_CLEAR_OVF,
			mcf_pkg::OP_SET_CARRY, mcf_pkg::OP_SET_MASK, mcf_pkg::OP_SET_OVF,
			mcf_pkg::OP_NEGATE_A, mcf_pkg::OP_DEC_ADJUST, mcf_pkg::OP_DEC_A,
			mcf_pkg::OP_INC_A, mcf_pkg::OP_ACC_TO_CCR: d = '{1'b1, 4'h2, 2'h1};
			default:                  d = '{1'b0, 4'h2, 2'h1};
		endcase
		return d;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	mcf_pkg::mcf_state_type state_ff;
	mcf_pkg::mcf_state_type nxt_state;
	mcf_pkg::mcf_arch_type  arch_ff;
	mcf_pkg::mcf_arch_type  nxt_arch;
	mcf_pkg::mcf_arch_type  execOut;
	mcf_pkg::mcf_decode_type dec;
	logic [7:0]  opcode_ff;
	logic [31:0] operand_ff;
	logic [11:0] cnt_ff;
	logic [11:0] nxt_cnt;
	logic        illegal_ff;
	logic        irqPend_ff;
	logic        nmiPend_ff;
	logic        maskAtWait_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] rdMux;
	logic        rdHit;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire setupPhase = psel & ~penable;
	wire wrAccess   = psel & penable & pwrite & pready_ff;
	wire wrOpcode   = wrAccess & (paddr == mcf_pkg::ADDR_OPCODE);
	wire wrOperand  = wrAccess & (paddr == mcf_pkg::ADDR_OPERAND);
	wire wrAcc      = wrAccess & (paddr == mcf_pkg::ADDR_ACC);
	wire wrCcr      = wrAccess & (paddr == mcf_pkg::ADDR_CCR);
	wire wrIntReq   = wrAccess & (paddr == mcf_pkg::ADDR_INTREQ);
	wire wrIndex    = wrAccess & (paddr == mcf_pkg::ADDR_INDEX);
	wire wrPc       = wrAccess & (paddr == mcf_pkg::ADDR_PC);
	wire isIdle     = (state_ff == mcf_pkg::MCF_IDLE);
	wire startExec  = wrOpcode & isIdle & decodeOp(pwdata[7:0]).known;
	wire badOpcode  = wrOpcode & isIdle & ~decodeOp(pwdata[7:0]).known;
	wire execDone   = (state_ff == mcf_pkg::MCF_EXEC) & (cnt_ff == 12'h000);

	// The mask is judged as it stood on entry to the wait.
	wire wakeNmi    = nmiPend_ff;
	wire wakeIrq    = irqPend_ff & ~maskAtWait_ff;
	wire wake       = (state_ff == mcf_pkg::MCF_WAIT) & (wakeNmi | wakeIrq);

	// Reserved status fields read as zero so software may mask them freely.
	mcf_pkg::mcf_status_type statusWord;
	assign statusWord = '{zero: '0, state: state_ff, maskAtWait: maskAtWait_ff,
		nmiPending: nmiPend_ff, irqPending: irqPend_ff, illegal: illegal_ff,
		rsvd: '0, bytes: dec.bytes, cycles: dec.cycles, rsvdLow: '0};

	always_comb begin
		rdHit = 1'b1;
		if (paddr == mcf_pkg::ADDR_OPCODE) begin
			rdMux = {24'h000000, opcode_ff};
		end else if (paddr == mcf_pkg::ADDR_OPERAND) begin
			rdMux = operand_ff;
		end else if (paddr == mcf_pkg::ADDR_ACC) begin
			rdMux = {16'h0000, arch_ff.accB, arch_ff.accA};
		end else if (paddr == mcf_pkg::ADDR_CCR) begin
			rdMux = {26'h0000000, arch_ff.ccr};
		end else if (paddr == mcf_pkg::ADDR_STATUS) begin
			rdMux = statusWord;
		end else if (paddr == mcf_pkg::ADDR_RESULT) begin
			rdMux = {16'h0000, arch_ff.result};
		end else if (paddr == mcf_pkg::ADDR_INTREQ) begin
			rdMux = {30'h00000000, nmiPend_ff, irqPend_ff};
		end else if (paddr == mcf_pkg::ADDR_INDEX) begin
			rdMux = {16'h0000, arch_ff.index};
		end else if (paddr == mcf_pkg::ADDR_PC) begin
			rdMux = {16'h0000, arch_ff.pc};
		end else begin
			rdMux = 32'h00000000;
			rdHit = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Arithmetic for flag work
	// ----------------------------------------------------------------
	// Every candidate result is formed from committed state each cycle; the latched
	// opcode only picks which one is kept, so the cost is area rather than timing.
	wire [7:0]  accA     = arch_ff.accA;
	wire [7:0]  negRes   = 8'h00 - accA;
	wire [7:0]  incRes   = accA + mcf_pkg::BYTE_ONE;
	wire [7:0]  decRes   = accA - mcf_pkg::BYTE_ONE;
	wire        daaLoAdj = (accA[3:0] > mcf_pkg::BCD_MAX_DIGIT) | arch_ff.ccr[mcf_pkg::FLAG_H];
	wire        daaHiAdj = arch_ff.ccr[mcf_pkg::FLAG_C]
		| (accA[7:4] > mcf_pkg::BCD_MAX_DIGIT)
		| ((accA[7:4] > mcf_pkg::BCD_HI_LIMIT) & (accA[3:0] > mcf_pkg::BCD_MAX_DIGIT));
	wire [7:0]  daaCorr  = {daaHiAdj ? mcf_pkg::BCD_CORR : 4'h0,
		daaLoAdj ? mcf_pkg::BCD_CORR : 4'h0};
	wire [7:0]  daaRes   = accA + daaCorr;
	wire [15:0] opWord   = operand_ff[15:0];
	wire [15:0] cmpFull  = arch_ff.index - opWord;
	wire [7:0]  cmpHigh  = arch_ff.index[15:8] - opWord[15:8];
	wire        cmpOvf   = (arch_ff.index[15] ^ opWord[15]) & (arch_ff.index[15] ^ cmpHigh[7]);
	wire [15:0] relOff   = {{8{opWord[7]}}, opWord[7:0]};
	wire [15:0] idxTgt   = arch_ff.index + {8'h00, opWord[7:0]};

	// The status word reports the opcode that was last accepted or refused.
	assign dec = decodeOp(opcode_ff);

	// Flag bits are addressed by name so the layout lives in one place.
	always_comb begin
		execOut    = arch_ff;
		execOut.pc = arch_ff.pc + {14'h0000, dec.bytes};
		case (opcode_ff)
			mcf_pkg::OP_BRANCH_SUB:   execOut.pc = arch_ff.pc + mcf_pkg::PC_REL_BASE + relOff;
			mcf_pkg::OP_JUMP_SUB_EXT: execOut.pc = opWord;
			mcf_pkg::OP_JUMP_SUB_IDX: execOut.pc = idxTgt;
			mcf_pkg::OP_JUMP_EXT:     execOut.pc = opWord;
			mcf_pkg::OP_JUMP_IDX:     execOut.pc = idxTgt;
			mcf_pkg::OP_SUB_RETURN:   execOut.pc = opWord;
			mcf_pkg::OP_INT_RETURN: begin
				execOut.pc  = opWord;
				execOut.ccr = operand_ff[21:16];
			end
			mcf_pkg::OP_SOFT_TRAP: begin
				execOut.pc                 = opWord;
				execOut.ccr[mcf_pkg::FLAG_I] = 1'b1;
			end
			mcf_pkg::OP_CLEAR_ACC_A, mcf_pkg::OP_CLEAR_ACC_B,
			mcf_pkg::OP_CLEAR_EXT, mcf_pkg::OP_CLEAR_IDX: begin
				if (opcode_ff == mcf_pkg::OP_CLEAR_ACC_A) begin
					execOut.accA = 8'h00;
				end else if (opcode_ff == mcf_pkg::OP_CLEAR_ACC_B) begin
					execOut.accB = 8'h00;
				end else begin
					execOut.result = 16'h0000;
				end
				execOut.ccr[mcf_pkg::FLAG_N] = 1'b0;
				execOut.ccr[mcf_pkg::FLAG_Z] = 1'b1;
				execOut.ccr[mcf_pkg::FLAG_V] = 1'b0;
				execOut.ccr[mcf_pkg::FLAG_C] = 1'b0;
			end
			mcf_pkg::OP_CLEAR_CARRY: execOut.ccr[mcf_pkg::FLAG_C] = 1'b0;
			mcf_pkg::OP_CLEAR_MASK:  execOut.ccr[mcf_pkg::FLAG_I] = 1'b0;
			mcf_pkg::OP_CLEAR_OVF:   execOut.ccr[mcf_pkg::FLAG_V] = 1'b0;
			mcf_pkg::OP_SET_CARRY:   execOut.ccr[mcf_pkg::FLAG_C] = 1'b1;
			mcf_pkg::OP_SET_MASK:    execOut.ccr[mcf_pkg::FLAG_I] = 1'b1;
			mcf_pkg::OP_SET_OVF:     execOut.ccr[mcf_pkg::FLAG_V] = 1'b1;
			mcf_pkg::OP_NEGATE_A: begin
				execOut.accA                 = negRes;
				execOut.ccr[mcf_pkg::FLAG_N] = negRes[7];
				execOut.ccr[mcf_pkg::FLAG_Z] = (negRes == 8'h00);
				execOut.ccr[mcf_pkg::FLAG_V] = (negRes == mcf_pkg::BYTE_MIN_NEG);
				execOut.ccr[mcf_pkg::FLAG_C] = (negRes == 8'h00);
			end
			mcf_pkg::OP_DEC_ADJUST: begin
				execOut.accA                 = daaRes;
				execOut.ccr[mcf_pkg::FLAG_N] = daaRes[7];
				execOut.ccr[mcf_pkg::FLAG_Z] = (daaRes == 8'h00);
				execOut.ccr[mcf_pkg::FLAG_C] = daaHiAdj;
			end
			mcf_pkg::OP_DEC_A: begin
				execOut.accA                 = decRes;
				execOut.ccr[mcf_pkg::FLAG_N] = decRes[7];
				execOut.ccr[mcf_pkg::FLAG_Z] = (decRes == 8'h00);
				execOut.ccr[mcf_pkg::FLAG_V] = (accA == mcf_pkg::BYTE_MIN_NEG);
			end
			mcf_pkg::OP_INC_A: begin
				execOut.accA                 = incRes;
				execOut.ccr[mcf_pkg::FLAG_N] = incRes[7];
				execOut.ccr[mcf_pkg::FLAG_Z] = (incRes == 8'h00);
				execOut.ccr[mcf_pkg::FLAG_V] = (accA == mcf_pkg::BYTE_MAX_POS);
			end
			mcf_pkg::OP_COMPARE_IDX: begin
				execOut.result               = cmpFull;
				execOut.ccr[mcf_pkg::FLAG_N] = cmpHigh[7];
				execOut.ccr[mcf_pkg::FLAG_Z] = (cmpFull == 16'h0000);
				execOut.ccr[mcf_pkg::FLAG_V] = cmpOvf;
			end
			mcf_pkg::OP_LOAD_IDX: begin
				execOut.index                = opWord;
				execOut.ccr[mcf_pkg::FLAG_N] = opWord[15];
				execOut.ccr[mcf_pkg::FLAG_Z] = (opWord == 16'h0000);
				execOut.ccr[mcf_pkg::FLAG_V] = 1'b0;
			end
			mcf_pkg::OP_ACC_TO_CCR: execOut.ccr = accA[5:0];
			default: execOut.ccr = arch_ff.ccr;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Software may only touch the machine registers while it is idle, so a
	// commit never races a bus write.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_arch  = arch_ff;
		case (state_ff)
			mcf_pkg::MCF_IDLE: begin
				if (wrAcc) begin
					nxt_arch.accA = pwdata[7:0];
					nxt_arch.accB = pwdata[15:8];
				end
				if (wrCcr) begin
					nxt_arch.ccr = pwdata[5:0];
				end
				if (wrIndex) begin
					nxt_arch.index = pwdata[15:0];
				end
				if (wrPc) begin
					nxt_arch.pc = pwdata[15:0];
				end
				if (startExec) begin
					nxt_state = mcf_pkg::MCF_EXEC;
					// One less than the span, so the commit lands on the edge the span ends.
					nxt_cnt   = 12'(decodeOp(pwdata[7:0]).cycles * CLKS_PER_CYC - 1);
				end
			end
			mcf_pkg::MCF_EXEC: begin
				if (cnt_ff != 12'h000) begin
					nxt_cnt = cnt_ff - 12'h001;
				end else begin
					nxt_arch  = execOut;
					nxt_state = (opcode_ff == mcf_pkg::OP_IDLE_WAIT) ?
						mcf_pkg::MCF_WAIT : mcf_pkg::MCF_IDLE;
				end
			end
			mcf_pkg::MCF_WAIT: begin
				if (wake) begin
					nxt_arch.ccr[mcf_pkg::FLAG_I] = 1'b1;
					nxt_state                     = mcf_pkg::MCF_IDLE;
				end
			end
			default: nxt_state = mcf_pkg::MCF_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= mcf_pkg::MCF_IDLE;
			cnt_ff   <= 12'h000;
			arch_ff  <= '{ccr: mcf_pkg::CCR_RESET, default: '0};
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			arch_ff  <= nxt_arch;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			opcode_ff  <= 8'h00;
			operand_ff <= 32'h00000000;
			illegal_ff <= 1'b0;
		end else begin
			if (startExec | badOpcode) begin
				opcode_ff <= pwdata[7:0];
			end
			if (wrOperand & isIdle) begin
				operand_ff <= pwdata;
			end
			if (badOpcode) begin
				illegal_ff <= 1'b1;
			end else if (startExec) begin
				illegal_ff <= 1'b0;
			end
		end
	end

	// Software cannot withdraw a request; only a wake consumes it.
	// A request written in the same edge that a wake consumes it survives.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqPend_ff    <= 1'b0;
			nmiPend_ff    <= 1'b0;
			maskAtWait_ff <= 1'b0;
		end else begin
			irqPend_ff <= (wrIntReq & pwdata[0]) | (irqPend_ff & ~(wake & wakeIrq & ~wakeNmi));
			nmiPend_ff <= (wrIntReq & pwdata[1]) | (nmiPend_ff & ~(wake & wakeNmi));
			if (execDone) begin
				maskAtWait_ff <= execOut.ccr[mcf_pkg::FLAG_I];
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	// Read data is captured in the setup cycle so the outputs leave flip-flops.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_ff  <= 32'h00000000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			cpuWaiting <= 1'b0;
		end else begin
			prdata_ff  <= setupPhase ? rdMux : 32'h00000000;
			pready_ff  <= setupPhase;
			pslverr_ff <= setupPhase & ~rdHit;
			cpuWaiting <= (nxt_state == mcf_pkg::MCF_WAIT);
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

endmodule

// ===== tb/mcf_control_flow_sva.sv
`timescale 1ns/1ps
module mcf_control_flow_sva #(
	parameter int unsigned CLKS_PER_CYC = 2
) (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cpuWaiting
);
	// ----------------------------------------------------------------
	// Bus and wait-state checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	localparam int WAIT_DLY = 9 * CLKS_PER_CYC;
	wire unmapped = (paddr[1:0] != 2'b00) || (paddr > 8'h20);
	wire taken    = psel && penable && pready && pwrite;
	wire reqWr    = taken && (paddr == 8'h18);
	sequence s_setup; psel && !penable; endsequence
	sequence s_idle_op; taken && paddr == 8'h00 && pwdata[7:0] == 8'h3E && !cpuWaiting; endsequence
	property p_ready_next; s_setup |=> pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_ready_access; pready |-> psel && penable; endproperty
	property p_err_unmapped; s_setup ##0 unmapped |=> pslverr; endproperty
	property p_err_mapped; s_setup ##0 !unmapped |=> !pslverr; endproperty
	property p_data_idle; !pready |-> prdata == 32'h0000_0000; endproperty
	property p_wait_entry; s_idle_op |-> ##WAIT_DLY !cpuWaiting ##1 cpuWaiting; endproperty
	property p_wait_exit;
		$fell(cpuWaiting) |-> $past(reqWr, 1) || $past(reqWr, 2) || $past(reqWr, 3);
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	a_ready_access: assert property (p_ready_access) else $error("ready outside access");
	a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
	a_err_mapped: assert property (p_err_mapped) else $error("error on mapped address");
	a_data_idle: assert property (p_data_idle) else $error("read data not zero");
	a_wait_entry: assert property (p_wait_entry) else $error("wait entry timing");
	a_wait_exit: assert property (p_wait_exit) else $error("wait left with no request");
endmodule
bind mcf_control_flow mcf_control_flow_sva #(.CLKS_PER_CYC(CLKS_PER_CYC)) sva_u (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cpuWaiting(cpuWaiting)
);

// ===== tb/mcf_apb_host.sv
`timescale 1ns/1ps
module mcf_apb_host (
	input  wire logic        ref_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// ----------------------------------------------------------------
	// Bus master on the system side of the register file
	// ----------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// The idle edge at the end keeps two transfers from touching psel in one step.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
endmodule

// ===== tb/mcf_control_flow_test.sv
`timescale 1ns/1ps
module mcf_control_flow_test;
	logic        ref_clk;
	logic        sys_rst;
	logic        psel, penable, pwrite, pready, pslverr, cpuWaiting, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, o;
	logic [15:0] p, x;
	logic [5:0]  c;
	int          mismatches = 0;
	int          numChecks  = 0;
	logic [15:0] tbl [0:18] = '{16'h8D82, 16'hBD93, 16'hAD82, 16'h7E33, 16'h6E42, 16'h3951,
		16'h3BA1, 16'h3FC1, 16'h0221, 16'h4F21, 16'h5F21, 16'h7F63, 16'h6F72, 16'h0C21,
		16'h0E21, 16'h0A21, 16'h0D21, 16'h0F21, 16'h0B21};
	logic [39:0] ar [0:11] = '{40'h4C7F000202, 40'h4C80000200, 40'h4A80000202,
		40'h4A7F000200, 40'h4080000202, 40'h4000000101, 40'h19A0000101, 40'h1912010101,
		40'h8C7F000A0A, 40'h8C80000A00, 40'hCE00000808, 40'h062D003F2D};
	mcf_control_flow #(.CLKS_PER_CYC(2)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuWaiting(cpuWaiting));
	mcf_apb_host host_u (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ----------------------------------------------------------------
	// Helpers and expectations
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'b1, a, d, q, err);
	endtask
	task automatic rd(input logic [7:0] a);
		host_u.xfer(1'b0, a, 32'h0000_0000, q, err);
	endtask
	// Leaves the last status word in q once execution has left the busy state.
	task automatic run(input logic [7:0] op);
		int n;
		n = 0;
		wr(8'h00, {24'h000000, op});
		do begin
			rd(8'h10);
			n++;
		end while (q[17:16] === 2'b01 && n < 50);
		if (n >= 50) mismatches++;
	endtask
	function automatic logic [5:0] exp_ccr(input logic [7:0] op, input logic [5:0] f);
		case (op)
			8'h0C: return f & 6'h3E;
			8'h0E: return f & 6'h2F;
			8'h0A: return f & 6'h3D;
			8'h0D: return f | 6'h01;
			8'h0F, 8'h3F: return f | 6'h10;
			8'h0B: return f | 6'h02;
			8'h4F, 8'h5F, 8'h7F, 8'h6F: return (f & 6'h30) | 6'h04;
			default: return f;
		endcase
	endfunction
	function automatic logic [15:0] exp_pc(input logic [7:0] op, input logic [15:0] pc,
		input logic [15:0] ix, input logic [15:0] w, input logic [1:0] b);
		case (op)
			8'h7E, 8'hBD, 8'h39, 8'h3B, 8'h3F: return w;
			8'h6E, 8'hAD: return ix + {8'h00, w[7:0]};
			8'h8D: return pc + 16'h0002 + {{8{w[7]}}, w[7:0]};
			default: return pc + {14'h0000, b};
		endcase
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
	initial begin
		sys_rst = 1'b1;
		void'($urandom(32'h2691));
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(8'h0C);
		chk(q, 32'h0000_0010);
		rd(8'h24);
		chk({31'h0, err}, 32'h0000_0001);
		wr(8'h00, 32'h0000_0001);
		rd(8'h10);
		chk(q & 32'h0003_1000, 32'h0000_1000);
		foreach (tbl[i]) begin
			c = 6'($urandom());
			o = $urandom();
			p = 16'($urandom());
			x = 16'($urandom());
			wr(8'h0C, {26'h0, c});
			wr(8'h04, o);
			wr(8'h1C, {16'h0000, x});
			wr(8'h20, {16'h0000, p});
			run(tbl[i][15:8]);
			chk({26'h0, q[7:2]}, {26'h0, tbl[i][1:0], tbl[i][7:4]});
			rd(8'h20);
			chk(q, {16'h0000, exp_pc(tbl[i][15:8], p, x, o[15:0], tbl[i][1:0])});
			rd(8'h0C);
			if (tbl[i][15:8] == 8'h3B) chk(q, {26'h0, o[21:16]});
			else chk(q, {26'h0, exp_ccr(tbl[i][15:8], c)});
		end
		foreach (ar[i]) begin
			wr(8'h0C, {24'h0, ar[i][23:16]});
			wr(8'h08, {24'h0, ar[i][31:24]});
			wr(8'h1C, {16'h0, ar[i][31:24], 8'h00});
			wr(8'h04, 32'h0000_8000);
			run(ar[i][39:32]);
			rd(8'h0C);
			chk(q & {24'h0, ar[i][15:8]}, {24'h0, ar[i][7:0]});
		end
		for (int m = 0; m < 2; m++) begin
			wr(8'h0C, (m == 0) ? 32'h0000_0000 : 32'h0000_0010);
			run(8'h3E);
			chk({24'h0, q[17:16], q[7:2]}, 32'h0000_0099);
			chk({31'h0, cpuWaiting}, 32'h0000_0001);
			wr(8'h18, 32'h0000_0001);
			rd(8'h10);
			chk({31'h0, cpuWaiting}, {31'h0, m[0]});
			// The masked pass stays waiting until an NMI request wakes it; the IRQ stays pending.
			wr(8'h18, {30'h0, m[0], 1'b0});
			rd(8'h0C);
			chk({31'h0, cpuWaiting, q[4]}, 32'h0000_0001);
		end
		finish_test();
	end
endmodule
